// ### hw/mailbox_pkg.sv
// Constants for the channel register sets and the message mailbox
package mailbox_pkg;
   localparam int       N_CHAN      = 14;
   localparam int       FIFO_W      = 8;
   localparam int       FIFO_D      = 16;
   localparam logic [7:0] CHAN_BASE = 8'h10;
   localparam logic [7:0] MBOX_BASE = 8'h80;
   // Offsets inside one channel set
   localparam logic [2:0] OFS_TAG_HI  = 3'h0;
   localparam logic [2:0] OFS_TAG_LO  = 3'h1;
   localparam logic [2:0] OFS_PTR     = 3'h2;
   localparam logic [2:0] OFS_LEN     = 3'h3;
   localparam logic [2:0] OFS_MASK_HI = 3'h6;
   localparam logic [2:0] OFS_MASK_LO = 3'h7;
   // Command nibble bit positions
   localparam int CMD_EXT = 3;
   localparam int CMD_ACK = 2;
   localparam int CMD_RNW = 1;
   localparam int CMD_RTR = 0;
   // Channel status bit positions
   localparam int ST_ERR = 2;
   localparam int ST_TXD = 1;
   localparam int ST_RXD = 0;
   localparam int PTR_SPY = 7;
   localparam logic [4:0] LEN_LINK = 5'h00;
   localparam logic [4:0] LEN_ONE  = 5'h01;
   localparam logic [6:0] PTR_ONE  = 7'h01;
   localparam logic [3:0] CHAN_LAST = 4'hD;
endpackage

// ### hw/channel_mailbox_regs.sv
// Channel register sets, receive buffering FIFO and message mailbox
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         clk,      // Clock
   input  wire logic         reset,    // Async reset
   input  wire logic         in_valid, // Fill side valid
   input  wire logic [W-1:0] in_data,  // Fill side data
   output logic              in_ready, // Not full
   output logic              out_valid,// Not empty
   output logic [W-1:0]      out_data, // Head word
   input  wire logic         out_ready // Drain side ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0]   cnt_q;
   logic          push, pop;
   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk)
   begin
      if (push) mem_q[wp_q] <= in_data;
   end
endmodule // byte_fifo

module channel_mailbox_regs (
   input  wire logic        clk,           // 25 MHz clock
   input  wire logic        reset,         // Async reset, active high
   input  wire logic [7:0]  reg_addr,      // Host byte address
   input  wire logic        reg_wr,        // Host write strobe
   input  wire logic        reg_rd,        // Host read strobe
   input  wire logic [7:0]  reg_wdata,     // Host write data
   output logic      [7:0]  reg_rdata,     // Read data, cycle after strobe
   input  wire logic        rx_hdr_valid,  // Received header pulse
   input  wire logic [11:0] rx_ident,      // Received identifier
   input  wire logic        rx_ext,        // Received extension bit
   input  wire logic        rx_ack_request_bit, // Received ack request
   input  wire logic        rx_read_request_bit,// Received read request
   input  wire logic        rx_reply_type_bit,  // Received reply type
   output logic             rx_hit,        // Header matched a channel
   output logic      [3:0]  rx_hit_chan,   // Matched channel
   output logic             rx_ack_enable, // Send acknowledge
   output logic             rx_busy,       // Frame in progress
   input  wire logic        rx_byte_valid, // Data byte valid
   input  wire logic [7:0]  rx_byte,       // Data byte
   output logic             rx_byte_ready, // Byte accepted
   input  wire logic        rx_end_valid,  // End of frame pulse
   input  wire logic        rx_end_ok,     // Frame error free
   output logic             rx_ack_ok_event,   // Rx ok, ack requested
   output logic             rx_noack_ok_event, // Rx ok, no ack requested
   output logic             rx_error_event,    // Rx with error
   output logic             tx_pending,    // A channel wants to send
   output logic      [3:0]  tx_chan,       // Sending channel
   output logic      [6:0]  tx_ptr,        // Its buffer offset
   output logic      [4:0]  tx_len,        // Its reserved length
   input  wire logic [6:0]  tx_rd_addr,    // Mailbox read offset
   output logic      [7:0]  tx_rd_data,    // Mailbox byte, next cycle
   input  wire logic        tx_result_valid, // Transmission finished
   input  wire logic [3:0]  tx_result_chan,  // Channel it was for
   input  wire logic        tx_result_ok,    // Without error
   input  wire logic        tx_retry_over,   // Retry count exceeded
   output logic             tx_abort,      // Abort pulse
   output logic      [3:0]  tx_abort_chan  // Channel to abort
);
   localparam int N = mailbox_pkg::N_CHAN;
   // No reset on these: contents survive reset
   logic [11:0] tag_q [N];
   logic [3:0]  cmd_q [N];
   logic [7:0]  ptr_q [N];
   logic [4:0]  len_q [N];
   logic [2:0]  st_q  [N];
   logic [2:0]  st_d  [N];
   logic [11:0] mask_q[N];
   logic [7:0]  mbox_q[128];

   function automatic logic rx_type(input logic [3:0] c, input logic [2:0] s);
      logic rn;
      logic rt;
      rn = c[mailbox_pkg::CMD_RNW];
      rt = c[mailbox_pkg::CMD_RTR];
      // Receive, reply request awaiting reply, request detector
      return (rt && !s[mailbox_pkg::ST_RXD]) ||
             (rn && !rt && s[mailbox_pkg::ST_TXD] && !s[mailbox_pkg::ST_RXD]);
   endfunction

   function automatic logic tx_type(input logic [3:0] c, input logic [2:0] s);
      logic rn;
      logic rt;
      rn = c[mailbox_pkg::CMD_RNW];
      rt = c[mailbox_pkg::CMD_RTR];
      // Transmit, reply request, immediate or deferred reply
      return !s[mailbox_pkg::ST_TXD] && ((rn == rt) ? (!rt || !s[mailbox_pkg::ST_RXD]) : rn);
   endfunction

   function automatic logic [4:0] first_set(input logic [N-1:0] v);
      logic [4:0] r;
      r = '0;
      // Lowest index wins
      for (int i = N - 1; i >= 0; i--)
         if (v[i]) r = {1'b1, 4'(i)};
      return r;
   endfunction

   // Length passed in, so a continuous assign sees every input it depends on
   function automatic logic [3:0] link_of(input logic [3:0] c, input logic [3:0] l, input logic [4:0] n);
      // Single link level only; software keeps it so
      return (n == mailbox_pkg::LEN_LINK && l <= mailbox_pkg::CHAN_LAST) ? l : c;
   endfunction

   // Host decode of the 0x10 + 8*n sets
   wire        h_mbox = reg_addr[7];
   wire [7:0]  h_rel  = reg_addr - mailbox_pkg::CHAN_BASE;
   wire [3:0]  h_chan = h_rel[6:3];
   wire [2:0]  h_ofs  = reg_addr[2:0];
   wire        h_set  = !h_mbox && (reg_addr >= mailbox_pkg::CHAN_BASE);

   // Identifier matching
   logic [N-1:0] match_v;
   logic [N-1:0] tx_v;
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         match_v[i] = (((rx_ident ^ tag_q[i]) & mask_q[i]) == '0) &&
                      (rx_ext == cmd_q[i][mailbox_pkg::CMD_EXT]) && rx_type(cmd_q[i], st_q[i]);
         tx_v[i] = tx_type(cmd_q[i], st_q[i]);
      end
   end
   wire [4:0] m_first = first_set(match_v);
   wire [4:0] t_first = first_set(tx_v);
   wire [3:0] m_buf   = link_of(m_first[3:0], ptr_q[m_first[3:0]][3:0], len_q[m_first[3:0]]);
   wire [3:0] t_buf   = link_of(t_first[3:0], ptr_q[t_first[3:0]][3:0], len_q[t_first[3:0]]);

   // Frame context
   logic        busy_q, hit_q, end_q, ok_q, spy_q;
   logic [3:0]  hchan_q, bchan_q;
   logic [6:0]  base_q;
   logic [4:0]  room_q, cnt_q;
   logic [11:0] ident_q;
   logic [2:0]  rcmd_q;

   logic       f_valid, f_ready;
   logic [7:0] f_data;
   wire  f_in_valid = rx_byte_valid && busy_q && hit_q;
   logic f_in_ready;
   byte_fifo #(.W(mailbox_pkg::FIFO_W), .D(mailbox_pkg::FIFO_D)) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (f_in_valid),
      .in_data   (rx_byte),
      .in_ready  (f_in_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_ready)
   );
   // Unmatched frames are swallowed; host mailbox writes stall the drain
   assign rx_byte_ready = hit_q ? f_in_ready : 1'b1;
   wire  h_mb_wr = reg_wr && h_mbox;
   assign f_ready = !h_mb_wr;
   wire  drain   = f_valid && f_ready;
   // Bytes beyond the reserved length are dropped
   // One bit wider so a saturated count never wraps back into room
   wire  in_room = ({1'b0, cnt_q} + 6'(mailbox_pkg::LEN_ONE)) < {1'b0, room_q};
   wire  fin     = busy_q && end_q && !f_valid && !h_mb_wr;
   wire  fin_ok  = fin && hit_q && ok_q;
   wire  fin_err = fin && hit_q && !ok_q;
   wire [4:0] rx_count = cnt_q + mailbox_pkg::LEN_ONE;
   wire [7:0] status_byte = {rcmd_q, rx_count};

   // Mailbox write port, wrap within 7 bits
   wire       mb_we    = h_mb_wr || fin_ok || (drain && in_room);
   localparam logic [6:0] PTR_ONE_W = mailbox_pkg::PTR_ONE;
   wire [6:0] d_addr   = base_q + PTR_ONE_W + 7'(cnt_q);
   wire [6:0] mb_waddr = h_mb_wr ? reg_addr[6:0] : (fin_ok ? base_q : d_addr);
   wire [7:0] mb_wdata = h_mb_wr ? reg_wdata : (fin_ok ? status_byte : f_data);

   always_ff @(posedge clk)
   begin
      if (mb_we) mbox_q[mb_waddr] <= mb_wdata;
      tx_rd_data <= mbox_q[tx_rd_addr];
   end

   // Status next value: host write first, device sets OR on top
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         st_d[i] = (reg_wr && h_set && h_chan == 4'(i) && h_ofs == mailbox_pkg::OFS_LEN) ?
                   reg_wdata[2:0] : st_q[i];
         if ((fin_err && hchan_q == 4'(i)) || (tx_result_valid && tx_result_chan == 4'(i) &&
             !tx_result_ok && !tx_retry_over))
            st_d[i][mailbox_pkg::ST_ERR] = 1'b1;
         if (tx_result_valid && tx_result_chan == 4'(i) && (tx_result_ok || tx_retry_over))
            st_d[i][mailbox_pkg::ST_TXD] = 1'b1;
         if (fin_ok && bchan_q == 4'(i))
            st_d[i][mailbox_pkg::ST_RXD] = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < N; i++)
      begin
         if (reg_wr && h_set && h_chan == 4'(i))
         begin
            unique case (h_ofs)
               mailbox_pkg::OFS_TAG_HI:  tag_q[i][11:4] <= reg_wdata;
               mailbox_pkg::OFS_TAG_LO:  {tag_q[i][3:0], cmd_q[i]} <= reg_wdata;
               mailbox_pkg::OFS_PTR:     ptr_q[i] <= reg_wdata;
               mailbox_pkg::OFS_LEN:     len_q[i] <= reg_wdata[7:3];
               mailbox_pkg::OFS_MASK_HI: mask_q[i][11:4] <= reg_wdata;
               mailbox_pkg::OFS_MASK_LO: mask_q[i][3:0] <= reg_wdata[7:4];
               default: ;
            endcase
         end
         if (fin_ok && hchan_q == 4'(i))
            tag_q[i] <= ident_q;
         st_q[i] <= st_d[i];
      end
   end

   // Host read mux; gaps and control area read as zero
   logic [7:0] set_rd;
   always_comb
   begin
      unique case (h_ofs)
         mailbox_pkg::OFS_TAG_HI:  set_rd = tag_q[h_chan][11:4];
         mailbox_pkg::OFS_TAG_LO:  set_rd = {tag_q[h_chan][3:0], cmd_q[h_chan]};
         mailbox_pkg::OFS_PTR:     set_rd = ptr_q[h_chan];
         mailbox_pkg::OFS_LEN:     set_rd = {len_q[h_chan], st_q[h_chan]};
         mailbox_pkg::OFS_MASK_HI: set_rd = mask_q[h_chan][11:4];
         mailbox_pkg::OFS_MASK_LO: set_rd = {mask_q[h_chan][3:0], 4'h0};
         default:                  set_rd = 8'h00;
      endcase
   end
   wire [7:0] rd_sel = h_mbox ? mbox_q[reg_addr[6:0]] : (h_set ? set_rd : 8'h00);
   wire abort_wr = reg_wr && h_set && h_ofs == mailbox_pkg::OFS_LEN &&
                   reg_wdata[mailbox_pkg::ST_ERR];

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         reg_rdata <= 8'h00;
         tx_abort <= 1'b0;
         tx_abort_chan <= 4'h0;
         tx_pending <= 1'b0;
         tx_chan <= 4'h0;
         tx_ptr <= 7'h00;
         tx_len <= 5'h00;
      end
      else
      begin
         if (reg_rd) reg_rdata <= rd_sel;
         tx_abort <= abort_wr;
         tx_abort_chan <= h_chan;
         tx_pending <= t_first[4];
         tx_chan <= t_first[3:0];
         tx_ptr <= ptr_q[t_buf][6:0];
         tx_len <= len_q[t_buf];
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         busy_q <= 1'b0;
         hit_q <= 1'b0;
         end_q <= 1'b0;
         ok_q <= 1'b0;
         spy_q <= 1'b0;
         hchan_q <= 4'h0;
         bchan_q <= 4'h0;
         base_q <= 7'h00;
         room_q <= 5'h00;
         cnt_q <= 5'h00;
         ident_q <= 12'h000;
         rcmd_q <= 3'h0;
      end
      else if (rx_hdr_valid && !busy_q)
      begin
         busy_q <= 1'b1;
         hit_q <= m_first[4];
         end_q <= 1'b0;
         spy_q <= ptr_q[m_first[3:0]][mailbox_pkg::PTR_SPY];
         hchan_q <= m_first[3:0];
         bchan_q <= m_buf;
         base_q <= ptr_q[m_buf][6:0];
         room_q <= len_q[m_buf];
         cnt_q <= 5'h00;
         ident_q <= rx_ident;
         rcmd_q <= {rx_ack_request_bit, rx_read_request_bit, rx_reply_type_bit};
      end
      else
      begin
         if (rx_end_valid && busy_q)
         begin
            end_q <= 1'b1;
            ok_q <= rx_end_ok;
         end
         if (drain && cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
         if (fin) busy_q <= 1'b0;
      end
   end

   assign rx_busy = busy_q;
   assign rx_hit = busy_q && hit_q;
   assign rx_hit_chan = hchan_q;
   assign rx_ack_enable = rx_hit && rcmd_q[2] && !spy_q;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rx_ack_ok_event <= 1'b0;
         rx_noack_ok_event <= 1'b0;
         rx_error_event <= 1'b0;
      end
      else
      begin
         rx_ack_ok_event <= fin_ok && rcmd_q[2];
         rx_noack_ok_event <= fin_ok && !rcmd_q[2];
         rx_error_event <= fin_err;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_hdr_spy;
      rx_hdr_valid && !busy_q && m_first[4] && ptr_q[m_first[3:0]][mailbox_pkg::PTR_SPY];
   endsequence
   sequence s_rx_done;
      fin_ok ##1 (rx_ack_ok_event || rx_noack_ok_event);
   endsequence
   sequence s_spy_fin;
      fin_ok && spy_q;
   endsequence
   chk_spy_no_ack: assert property (s_hdr_spy |=> rx_hit && !rx_ack_enable)
      else $error("ack enabled in spy mode");
   chk_spy_event: assert property (s_spy_fin |=> rx_ack_ok_event || rx_noack_ok_event)
      else $error("no event after spy reception");
   chk_low_wins: assert property (rx_hdr_valid && !busy_q && match_v != '0
      |=> rx_hit && ((($past(match_v) >> rx_hit_chan) & N'(1)) == N'(1)) &&
          (($past(match_v) & ((N'(1) << rx_hit_chan) - N'(1))) == '0))
      else $error("lowest channel lost");
   chk_inactive_none: assert property (rx_hdr_valid && !busy_q && match_v == '0 |=> !rx_hit)
      else $error("inactive channel hit");
   chk_tag_rewrite: assert property (fin_ok |=> tag_q[$past(hchan_q)] == $past(ident_q))
      else $error("tag not rewritten");
   chk_status_byte: assert property (s_rx_done |-> mbox_q[$past(base_q, 1)] == $past(status_byte))
      else $error("status byte wrong");
   chk_err_set: assert property (fin_err |=> st_q[$past(hchan_q)][mailbox_pkg::ST_ERR] && rx_error_event
      ##1 !rx_error_event)
      else $error("error bit not set");
   chk_abort_pulse: assert property (abort_wr |=> tx_abort && tx_abort_chan == $past(h_chan))
      else $error("abort not issued");
   chk_tx_done: assert property (tx_result_valid && tx_result_ok && tx_result_chan <= mailbox_pkg::CHAN_LAST
      |=> st_q[$past(tx_result_chan)][mailbox_pkg::ST_TXD])
      else $error("tx done not set");
endmodule // channel_mailbox_regs

`default_nettype wire

// ### bench/frame_engine_model.sv
// Frame engine stand-in: drives received frames and transmit outcomes
`timescale 1ns/1ps
`default_nettype none
module frame_engine_model (
   input  wire logic        clk,                 // Clock
   output logic             rx_hdr_valid,        // Header pulse
   output logic      [11:0] rx_ident,            // Identifier
   output logic             rx_ext,              // Compared command bit
   output logic             rx_ack_request_bit,  // Ack request
   output logic             rx_read_request_bit, // Read request
   output logic             rx_reply_type_bit,   // Reply type
   output logic             rx_byte_valid,       // Byte valid
   output logic      [7:0]  rx_byte,             // Byte
   input  wire logic        rx_byte_ready,       // Byte taken
   output logic             rx_end_valid,        // End pulse
   output logic             rx_end_ok,           // Error free
   output logic             tx_result_valid,     // Outcome pulse
   output logic      [3:0]  tx_result_chan,      // Outcome channel
   output logic             tx_result_ok,        // Outcome ok
   output logic             tx_retry_over        // Retries exceeded
);
   initial
   begin
      {rx_hdr_valid, rx_ident, rx_ext, rx_ack_request_bit, rx_read_request_bit, rx_reply_type_bit} = '0;
      {rx_byte_valid, rx_byte, rx_end_valid, rx_end_ok} = '0;
      {tx_result_valid, tx_result_chan, tx_result_ok, tx_retry_over} = '0;
   end

   // Command nibble order: compared bit, ack, read, reply
   task automatic send_frame(input logic [11:0] id, input logic [3:0] cmd, input int n,
                             input logic [7:0] b0, input logic ok);
      @(posedge clk);
      rx_hdr_valid <= 1'b1;
      rx_ident <= id;
      {rx_ext, rx_ack_request_bit, rx_read_request_bit, rx_reply_type_bit} <= cmd;
      @(posedge clk);
      rx_hdr_valid <= 1'b0;
      // Stale header must not look valid
      rx_ident <= ~id;
      for (int k = 0; k < n; k++)
      begin
         rx_byte_valid <= 1'b1;
         rx_byte <= b0 + 8'(k);
         @(negedge clk);
         while (rx_byte_ready !== 1'b1)
            @(negedge clk);
         @(posedge clk);
      end
      rx_byte_valid <= 1'b0;
      rx_byte <= ~rx_byte;
      rx_end_valid <= 1'b1;
      rx_end_ok <= ok;
      @(posedge clk);
      rx_end_valid <= 1'b0;
   endtask

   task automatic send_result(input logic [3:0] ch, input logic ok, input logic over);
      @(posedge clk);
      tx_result_valid <= 1'b1;
      tx_result_chan <= ch;
      tx_result_ok <= ok;
      tx_retry_over <= over;
      @(posedge clk);
      tx_result_valid <= 1'b0;
   endtask
endmodule // frame_engine_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the channel register sets and mailbox
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, reset, reg_wr, reg_rd, rx_hdr_valid, rx_ext, rx_ack_request_bit, rx_read_request_bit;
   logic        rx_reply_type_bit, rx_hit, rx_ack_enable, rx_busy, rx_byte_valid, rx_byte_ready;
   logic        rx_end_valid, rx_end_ok, rx_ack_ok_event, rx_noack_ok_event, rx_error_event;
   logic        tx_pending, tx_result_valid, tx_result_ok, tx_retry_over, tx_abort, last_ack;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rx_byte, tx_rd_data;
   logic [11:0] rx_ident;
   logic [3:0]  rx_hit_chan, tx_chan, tx_result_chan, tx_abort_chan, last_hit, last_abort;
   logic [6:0]  tx_ptr, tx_rd_addr;
   logic [4:0]  tx_len;
   int          miscompares = 0, checked = 0;
   int          ack_n = 0, noack_n = 0, err_n = 0, hit_n = 0, abort_n = 0;

   channel_mailbox_regs dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .rx_hdr_valid, .rx_ident, .rx_ext, .rx_ack_request_bit, .rx_read_request_bit, .rx_reply_type_bit,
      .rx_hit, .rx_hit_chan, .rx_ack_enable, .rx_busy, .rx_byte_valid, .rx_byte, .rx_byte_ready,
      .rx_end_valid, .rx_end_ok, .rx_ack_ok_event, .rx_noack_ok_event, .rx_error_event, .tx_pending,
      .tx_chan, .tx_ptr, .tx_len, .tx_rd_addr, .tx_rd_data, .tx_result_valid, .tx_result_chan,
      .tx_result_ok, .tx_retry_over, .tx_abort, .tx_abort_chan);
   frame_engine_model fe (.clk, .rx_hdr_valid, .rx_ident, .rx_ext, .rx_ack_request_bit,
      .rx_read_request_bit, .rx_reply_type_bit, .rx_byte_valid, .rx_byte, .rx_byte_ready, .rx_end_valid,
      .rx_end_ok, .tx_result_valid, .tx_result_chan, .tx_result_ok, .tx_retry_over);

   initial
   begin
      clk = 1'b0;
      forever
         #20 clk = ~clk;
   end

   // Pulses are counted, so a scenario compares deltas instead of racing them
   always @(posedge clk)
   begin
      ack_n <= ack_n + int'(rx_ack_ok_event === 1'b1);
      noack_n <= noack_n + int'(rx_noack_ok_event === 1'b1);
      err_n <= err_n + int'(rx_error_event === 1'b1);
      hit_n <= hit_n + int'(rx_hit === 1'b1);
      abort_n <= abort_n + int'(tx_abort === 1'b1);
      if (rx_hit === 1'b1)
         {last_ack, last_hit} <= {rx_ack_enable, rx_hit_chan};
      if (tx_abort === 1'b1)
         last_abort <= tx_abort_chan;
   end

   task automatic finish_test;
      $display("checked %0d, miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   function automatic logic [7:0] cb(input int ch, input int o);
      return mailbox_pkg::CHAN_BASE + 8'(8 * ch + o);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), {4'h0, e}, {4'h0, reg_rdata});
   endtask

   task automatic set_chan(input int ch, input logic [11:0] tag, input logic [3:0] cmd, input logic [7:0] ptr,
                           input logic [4:0] len, input logic [2:0] st, input logic [11:0] mask);
      wr(cb(ch, 0), tag[11:4]);
      wr(cb(ch, 1), {tag[3:0], cmd});
      wr(cb(ch, 2), ptr);
      wr(cb(ch, 3), {len, st});
      wr(cb(ch, 6), mask[11:4]);
      wr(cb(ch, 7), {mask[3:0], 4'hF});
   endtask

   // Channel 15 as expected channel means no hit at all
   task automatic frame(input logic [11:0] id, input logic [3:0] cmd, input int n, input logic [7:0] b0,
                        input logic ok, input int ev, input logic [3:0] ch, input logic ack);
      int a, b, e, h;
      a = ack_n;
      b = noack_n;
      e = err_n;
      h = hit_n;
      fe.send_frame(id, cmd, n, b0, ok);
      for (int i = 0; i < 30 && ack_n + noack_n + err_n == a + b + e; i++)
         @(negedge clk);
      chk("event", 12'(ev), 12'((ack_n - a) + 2 * (noack_n - b) + 4 * (err_n - e)));
      if (ch == 4'hF)
         chk("hit cycles", 12'h000, 12'(hit_n - h));
      else
         chk("hit channel", {7'h0, ack, ch}, {7'h0, last_ack, last_hit});
   endtask

   initial
   begin
      {reset, reg_wr, reg_rd, reg_addr, reg_wdata, tx_rd_addr} = {3'b100, 8'h00, 8'h00, 7'h00};
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      // Contents are random after power-up, so every set is made inactive first
      for (int c = 0; c < 14; c++)
         set_chan(c, 12'h000, 4'h0, 8'h00, 5'h01, 3'b011, 12'hFFF);
      rd_chk(cb(0, 3), 8'h0B);
      rd_chk(cb(13, 7), 8'hF0);
      rd_chk(cb(0, 4), 8'h00);
      rd_chk(8'h05, 8'h00);
      chk("tx pending", 12'h000, {11'h0, tx_pending});
      wr(cb(13, 0), 8'hAB);
      wr(cb(13, 1), 8'hC0);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      rd_chk(cb(13, 0), 8'hAB);
      rd_chk(cb(13, 1), 8'hC0);
      set_chan(2, 12'h5A3, 4'h9, 8'h7F, 5'h05, 3'b010, 12'hFF0);
      set_chan(5, 12'h5A0, 4'h9, 8'h90, 5'h05, 3'b010, 12'hFF0);
      frame(12'h5AC, 4'h5, 2, 8'h11, 1'b1, 0, 4'hF, 1'b0);
      frame(12'h5AC, 4'hD, 3, 8'h31, 1'b1, 1, 4'h2, 1'b1);
      rd_chk(cb(2, 0), 8'h5A);
      rd_chk(cb(2, 1), 8'hC9);
      rd_chk(cb(2, 3), 8'h2B);
      rd_chk(8'hFF, 8'hA4);
      rd_chk(8'h80, 8'h31);
      rd_chk(8'h82, 8'h33);
      @(posedge clk);
      tx_rd_addr <= 7'h7F;
      repeat (2) @(posedge clk);
      #1;
      chk("mailbox port", 12'h0A4, {4'h0, tx_rd_data});
      frame(12'h5AC, 4'hD, 0, 8'h00, 1'b1, 1, 4'h5, 1'b0);
      rd_chk(8'h90, 8'hA1);
      set_chan(7, 12'h000, 4'h0, 8'h20, 5'h03, 3'b010, 12'hFFF);
      set_chan(4, 12'h3C0, 4'h9, 8'h07, 5'h00, 3'b010, 12'hFFF);
      frame(12'h3C0, 4'h9, 2, 8'h41, 1'b1, 2, 4'h4, 1'b0);
      rd_chk(8'hA0, 8'h23);
      rd_chk(8'hA2, 8'h42);
      rd_chk(cb(7, 3), 8'h1B);
      rd_chk(cb(4, 3), 8'h02);
      set_chan(8, 12'h111, 4'h9, 8'h30, 5'h04, 3'b010, 12'hFFF);
      frame(12'h111, 4'h9, 1, 8'h55, 1'b0, 4, 4'h8, 1'b0);
      rd_chk(cb(8, 3), 8'h26);
      set_chan(10, 12'h333, 4'h0, 8'h50, 5'h02, 3'b000, 12'hFFF);
      set_chan(3, 12'h222, 4'h0, 8'h40, 5'h03, 3'b000, 12'hFFF);
      repeat (3) @(posedge clk);
      #1;
      chk("tx select", {1'b1, 4'h3, 7'h40}, {tx_pending, tx_chan, tx_ptr});
      chk("tx length", 12'h003, {7'h00, tx_len});
      fe.send_result(4'h3, 1'b1, 1'b0);
      rd_chk(cb(3, 3), 8'h1A);
      #1;
      chk("tx select", {1'b1, 4'hA, 7'h50}, {tx_pending, tx_chan, tx_ptr});
      fe.send_result(4'hA, 1'b0, 1'b0);
      rd_chk(cb(10, 3), 8'h14);
      wr(cb(10, 3), 8'h14);
      repeat (3) @(posedge clk);
      chk("abort", {8'h01, 4'hA}, {8'(abort_n), last_abort});
      fe.send_result(4'hA, 1'b0, 1'b1);
      rd_chk(cb(10, 3), 8'h16);
      // Steady host mailbox writes stall the drain, so a long frame fills the buffer
      set_chan(12, 12'h7E5, 4'h9, 8'h60, 5'h1F, 3'b010, 12'hFFF);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= 8'hFF;
      reg_wdata <= 8'h5C;
      fork
         frame(12'h7E5, 4'h9, 20, 8'h61, 1'b1, 2, 4'hC, 1'b0);
         begin
            repeat (22) @(posedge clk);
            @(negedge clk);
            chk("byte ready", 12'h000, {11'h0, rx_byte_ready});
            chk("busy", 12'h001, {11'h0, rx_busy});
            @(posedge clk);
            reg_wr <= 1'b0;
         end
      join
      rd_chk(8'hE0, 8'h35);
      rd_chk(8'hE1, 8'h61);
      rd_chk(8'hF4, 8'h74);
      rd_chk(8'hFF, 8'h5C);
      finish_test();
   end

   // About 500 cycles expected; the margin covers slow frame completion
   initial
   begin
      #(40 * 30000);
      miscompares++;
      finish_test();
   end
endmodule // tb
`default_nettype wire
